// *** scp_serial_port.sv ***
`include "scp_cfg.svh"

// ------------------------------------------------------------
// serial control port with its configuration register group
// ------------------------------------------------------------
// identity parameters: all default values are arbitrary
//
// frame as the core sees it
//   select low opens a frame, select high drops it at once
//   16 instruction bits: read flag, then a 15-bit address
//   data bytes follow msb first, taken on serial rises
//   read bits change after serial falls, each byte's msb after a rise
// timing limits
//   each serial clock phase must last three core cycles or
//   more, since edges are found by comparing two samples
//   pins are treated as synchronous; a host on an unrelated
//   clock needs synchronisers in front of them
// clock enable low freezes every register and hides edges
// read data is driven only while a read is under way; both
// data outputs carry the same bit and the mode picks the one
// whose enable is raised

module scp_serial_port #(
   parameter logic [7:0]  CATEGORY_CODE = 8'h3c,
   parameter logic [7:0]  IDENT_LO_CODE = 8'h5a,
   parameter logic [7:0]  IDENT_HI_CODE = 8'h11,
   parameter logic [7:0]  REVISION_CODE = 8'h02,
   parameter logic [15:0] MAKER_CODE    = 16'h1234
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        port_select_n,
   input  wire logic        serial_clk,
   input  wire logic        sdio_in,
   output logic             sdio_out,
   output logic             sdio_oe,
   output logic             sdo_out,
   output logic             sdo_oe,
   output scp_pkg::scp_pwr_t power_mode_field
);
   import scp_pkg::*;

   // ---------------------------------------------------------
   // address stepping, shared by read and write streams
   // ---------------------------------------------------------
   // wraps at both ends of the 15-bit space, the natural
   // behaviour of a pointer of that width
   function automatic scp_addr_t step_addr(
      input scp_addr_t a,
      input logic      up
   );
      step_addr = up ? scp_addr_t'(a + 15'h0001)
                     : scp_addr_t'(a - 15'h0001);
   endfunction

   // register access carrier between engine and register file
   scp_reg_if  bus ();

   // edge finder outputs
   logic       frame_on;
   logic       sclk_rise;
   logic       sclk_fall;

   // serial engine state
   scp_state_e state_reg;
   logic [4:0] bit_cnt_reg;
   logic [15:0] shin_reg;
   scp_addr_t  addr_reg;
   // write path holding registers
   scp_addr_t  wr_addr_reg;
   logic       wr_stb_reg;
   scp_byte_t  wdata_reg;
   // read path shifter
   logic [6:0] out_sh_reg;
   logic       out_bit_reg;

   // ---------------------------------------------------------
   // pin edge finder
   // ---------------------------------------------------------
   // edges are gated by the select, so clock activity between
   // frames can never advance the engine
   scp_edge u_edge (
      .core_clk      (core_clk),
      .rst           (rst),
      .clk_en        (clk_en),
      .serial_clk    (serial_clk),
      .port_select_n (port_select_n),
      .frame_on      (frame_on),
      .sclk_rise     (sclk_rise),
      .sclk_fall     (sclk_fall)
   );

   // ---------------------------------------------------------
   // register file
   // ---------------------------------------------------------
   // reads are answered combinationally from the address shown,
   // so a load needs no extra wait state
   scp_regfile #(
      .CATEGORY_CODE (CATEGORY_CODE),
      .IDENT_LO_CODE (IDENT_LO_CODE),
      .IDENT_HI_CODE (IDENT_HI_CODE),
      .REVISION_CODE (REVISION_CODE),
      .MAKER_CODE    (MAKER_CODE)
   ) u_regs (
      .core_clk         (core_clk),
      .rst              (rst),
      .clk_en           (clk_en),
      .bus              (bus.regs),
      .power_mode_field (power_mode_field)
   );

   // ---------------------------------------------------------
   // phase decode
   // ---------------------------------------------------------
   // idle also accepts instruction bits so the first edge of a
   // frame is never missed
   wire in_instr = (state_reg == ST_IDLE) |
                   (state_reg == ST_INSTR);
   wire in_read  = (state_reg == ST_READ);
   wire in_write = (state_reg == ST_WRITE);
   wire in_data  = in_read | in_write;
   wire in_load  = (state_reg == ST_LOAD);

   // serial input word with the bit arriving now appended
   wire [15:0] rx_word = {shin_reg[14:0], sdio_in};

   wire instr_done = sclk_rise & in_instr &
                     (bit_cnt_reg == `SCP_INSTR_LAST);
   wire byte_done  = sclk_rise & in_data &
                     (bit_cnt_reg == `SCP_BYTE_LAST);
   // instruction word: bit 15 read flag, bits 14:0 address
   wire is_read    = rx_word[`SCP_RD_BIT];

   // ---------------------------------------------------------
   // phase machine
   // ---------------------------------------------------------
   // load lasts one core cycle in which the register file is
   // read; the msb reaches the pins one cycle later, well ahead
   // of the next serial fall
   // select high always abandons the frame, even mid byte
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else if (clk_en) begin
         if (!frame_on) begin
            state_reg <= ST_IDLE;
         end else begin
            case (state_reg)
               ST_IDLE, ST_INSTR: begin
                  if (instr_done) begin
                     state_reg <= is_read ? ST_LOAD : ST_WRITE;
                  end else begin
                     state_reg <= ST_INSTR;
                  end
               end
               ST_LOAD: begin
                  state_reg <= ST_READ;
               end
               ST_READ: begin
                  if (byte_done) begin
                     // in single-byte mode one byte ends the access, select ignored
                     state_reg <= bus.single_byte ? ST_INSTR
                                                  : ST_LOAD;
                  end
               end
               // streaming writes stay here until the select rises
               ST_WRITE: begin
                  if (byte_done && bus.single_byte) begin
                     state_reg <= ST_INSTR;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------
   // bit counter and input shifter
   // ---------------------------------------------------------
   // counts rises within the instruction or the current byte;
   // no rise can arrive during a load, the guard only keeps the
   // count sane if a host breaks the phase limits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bit_cnt_reg <= 5'h00;
      end else if (clk_en) begin
         if (!frame_on || instr_done || byte_done) begin
            bit_cnt_reg <= 5'h00;
         end else if (sclk_rise && !in_load) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // the instruction is read from rx_word, not from this
   // register, so the 16th bit is used in the cycle it arrives
   // data is taken on the rising serial edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shin_reg <= 16'h0000;
      end else if (clk_en && sclk_rise) begin
         shin_reg <= rx_word;
      end
   end

   // ---------------------------------------------------------
   // address pointer
   // ---------------------------------------------------------
   // steps after every byte, reads and writes alike; after the
   // last read byte it points one past, which is harmless as a
   // new frame reloads it from the instruction
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_reg <= 15'h0000;
      end else if (clk_en) begin
         if (instr_done) begin
            addr_reg <= rx_word[14:0];
         end else if (byte_done) begin
            addr_reg <= step_addr(addr_reg, bus.asc);
         end
      end
   end

   // ---------------------------------------------------------
   // write strobe, one core cycle after the last data bit
   // ---------------------------------------------------------
   // a select that rises right after the last bit still lets
   // the strobe through, since the byte itself was complete
   // the pointer has already stepped, so the target is latched
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_stb_reg  <= 1'h0;
         wr_addr_reg <= 15'h0000;
         wdata_reg   <= 8'h00;
      end else if (clk_en) begin
         wr_stb_reg <= byte_done & in_write;
         if (byte_done) begin
            wr_addr_reg <= addr_reg;
            wdata_reg   <= rx_word[7:0];
         end
      end
   end

   assign bus.wr_stb = wr_stb_reg;
   assign bus.wdata  = wdata_reg;
   // reads look at the live pointer only while loading
   assign bus.addr   = in_load ? addr_reg : wr_addr_reg;

   // ---------------------------------------------------------
   // read shifter, msb first, changes on the falling edge
   // ---------------------------------------------------------
   // bits past the eighth shift in as zeros; in streaming the
   // next load replaces them before they reach the pins
   // the falling edge right after a load is skipped because the
   // msb was already placed by the load itself
   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_bit_reg <= 1'h0;
         out_sh_reg  <= 7'h00;
      end else if (clk_en) begin
         if (in_load) begin
            out_bit_reg <= bus.rdata[7];
            out_sh_reg  <= bus.rdata[6:0];
         end else if (sclk_fall && in_read &&
                      bit_cnt_reg != 5'h00) begin
            out_bit_reg <= out_sh_reg[6];
            out_sh_reg  <= {out_sh_reg[5:0], 1'h0};
         end
      end
   end

   // ---------------------------------------------------------
   // output pins
   // ---------------------------------------------------------
   // in three-wire reads the host must let go of the shared
   // line by the first read bit; the enable rises one cycle
   // after the 16th rise, before any read bit is due
   // the enable stays high across streamed bytes and drops with
   // the select, or at the end of a one-byte read
   // both data outputs carry the same bit, the mode picks which
   // one is enabled
   wire rd_drive = frame_on & (in_read | in_load);
   assign sdio_out = out_bit_reg;
   assign sdo_out  = out_bit_reg;
   assign sdio_oe  = rd_drive & ~bus.four_wire;
   assign sdo_oe   = rd_drive & bus.four_wire;
endmodule

// *** scp_cfg.svh ***
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// ------------------------------------------------------------
// register offsets of the serial port configuration group
// ------------------------------------------------------------
`define SCP_OFS_CFG_A     15'h0000
`define SCP_OFS_CFG_B     15'h0001
`define SCP_OFS_PWR       15'h0002
`define SCP_OFS_CATEGORY  15'h0003
`define SCP_OFS_IDENT_LO  15'h0004
`define SCP_OFS_IDENT_HI  15'h0005
`define SCP_OFS_REVISION  15'h0006
`define SCP_OFS_MAKER_LO  15'h000c
`define SCP_OFS_MAKER_HI  15'h000d
`define SCP_OFS_CFG_C     15'h000f
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define SCP_A_RST_BIT     7
`define SCP_A_ASC_BIT     5
`define SCP_A_4W_BIT      4
`define SCP_B_SINGLE_BIT  7
`define SCP_B_RDBUF_BIT   5
`define SCP_C_COMMIT_BIT  0
`define SCP_PWR_LO        0
`define SCP_PWR_HI        1
`define SCP_PWR_RESET     2'h0
`define SCP_FLAG_RESET    1'h0
// ------------------------------------------------------------
// serial framing
// ------------------------------------------------------------
`define SCP_RD_BIT        15
`define SCP_INSTR_LAST    5'h0f
`define SCP_BYTE_LAST     5'h07
`endif

// *** scp_pkg.sv ***
package scp_pkg;
   typedef logic [14:0] scp_addr_t;
   typedef logic [7:0]  scp_byte_t;
   typedef logic [1:0]  scp_pwr_t;
   // serial engine phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INSTR,
      ST_LOAD,
      ST_READ,
      ST_WRITE
   } scp_state_e;
endpackage

// *** scp_reg_if.sv ***
// register access between the serial engine and the register file
interface scp_reg_if;
   import scp_pkg::*;
   logic      wr_stb;
   scp_addr_t addr;
   scp_byte_t wdata;
   scp_byte_t rdata;
   logic      asc;
   logic      four_wire;
   logic      single_byte;
   modport engine (
      output wr_stb,
      output addr,
      output wdata,
      input  rdata,
      input  asc,
      input  four_wire,
      input  single_byte
   );
   modport regs (
      input  wr_stb,
      input  addr,
      input  wdata,
      output rdata,
      output asc,
      output four_wire,
      output single_byte
   );
endinterface

// *** scp_edge.sv ***
// serial clock edge finder, inputs are already core-synchronous
module scp_edge (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic serial_clk,
   input  wire logic port_select_n,
   output logic      frame_on,
   output logic      sclk_rise,
   output logic      sclk_fall
);
   logic sclk_prev_reg;

   // previous level, frozen with the clock enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclk_prev_reg <= 1'h0;
      end else if (clk_en) begin
         sclk_prev_reg <= serial_clk;
      end
   end

   // edges only count inside a frame and while enabled
   assign frame_on  = ~port_select_n;
   assign sclk_rise = clk_en & frame_on & serial_clk & ~sclk_prev_reg;
   assign sclk_fall = clk_en & frame_on & ~serial_clk & sclk_prev_reg;
endmodule

// *** scp_regfile.sv ***
`include "scp_cfg.svh"
// configuration, pending/active power mode and identity codes
module scp_regfile #(
   parameter logic [7:0] CATEGORY_CODE = 8'h3c,
   parameter logic [7:0] IDENT_LO_CODE = 8'h5a,
   parameter logic [7:0] IDENT_HI_CODE = 8'h11,
   parameter logic [7:0] REVISION_CODE = 8'h02,
   parameter logic [15:0] MAKER_CODE   = 16'h1234
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   scp_reg_if.regs         bus,
   output scp_pkg::scp_pwr_t power_mode_field
);
   import scp_pkg::*;

   logic     asc_reg;
   logic     four_wire_reg;
   logic     single_reg;
   logic     rdbuf_reg;
   scp_pwr_t pwr_pend_reg;
   scp_pwr_t pwr_act_reg;

   // ---------------------------------------------------------
   // write decode
   // ---------------------------------------------------------
   wire hit_a   = bus.wr_stb & (bus.addr == `SCP_OFS_CFG_A);
   wire hit_b   = bus.wr_stb & (bus.addr == `SCP_OFS_CFG_B);
   wire hit_pwr = bus.wr_stb & (bus.addr == `SCP_OFS_PWR);
   wire hit_c   = bus.wr_stb & (bus.addr == `SCP_OFS_CFG_C);
   // low nibble must be the high nibble bit-reversed
   wire mirror_ok = bus.wdata[3:0] ==
                    {bus.wdata[4], bus.wdata[5],
                     bus.wdata[6], bus.wdata[7]};
   wire take_a    = hit_a & mirror_ok;
   wire soft_rst  = take_a & bus.wdata[`SCP_A_RST_BIT];
   wire commit    = hit_c & bus.wdata[`SCP_C_COMMIT_BIT];

   // port configuration survives the soft reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         asc_reg       <= `SCP_FLAG_RESET;
         four_wire_reg <= `SCP_FLAG_RESET;
         single_reg    <= `SCP_FLAG_RESET;
         rdbuf_reg     <= `SCP_FLAG_RESET;
      end else if (clk_en) begin
         if (take_a) begin
            asc_reg       <= bus.wdata[`SCP_A_ASC_BIT];
            four_wire_reg <= bus.wdata[`SCP_A_4W_BIT];
         end
         if (hit_b) begin
            single_reg <= bus.wdata[`SCP_B_SINGLE_BIT];
            rdbuf_reg  <= bus.wdata[`SCP_B_RDBUF_BIT];
         end
      end
   end

   // double-buffered power mode, commit copies pending to active
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwr_pend_reg <= `SCP_PWR_RESET;
         pwr_act_reg  <= `SCP_PWR_RESET;
      end else if (clk_en) begin
         if (soft_rst) begin
            pwr_pend_reg <= `SCP_PWR_RESET;
            pwr_act_reg  <= `SCP_PWR_RESET;
         end else begin
            if (hit_pwr) begin
               pwr_pend_reg <= bus.wdata[`SCP_PWR_HI:`SCP_PWR_LO];
            end
            if (commit) begin
               pwr_act_reg <= pwr_pend_reg;
            end
         end
      end
   end

   // ---------------------------------------------------------
   // read selection; reset and commit bits always read zero
   // ---------------------------------------------------------
   wire scp_pwr_t pwr_view = rdbuf_reg ? pwr_pend_reg
                                       : pwr_act_reg;
   assign bus.rdata =
      (bus.addr == `SCP_OFS_CFG_A) ?
         {2'h0, asc_reg, four_wire_reg,
          four_wire_reg, asc_reg, 2'h0} :
      (bus.addr == `SCP_OFS_CFG_B) ?
         {single_reg, 1'h0, rdbuf_reg, 5'h00} :
      (bus.addr == `SCP_OFS_PWR)      ? {6'h00, pwr_view} :
      (bus.addr == `SCP_OFS_CATEGORY) ? CATEGORY_CODE :
      (bus.addr == `SCP_OFS_IDENT_LO) ? IDENT_LO_CODE :
      (bus.addr == `SCP_OFS_IDENT_HI) ? IDENT_HI_CODE :
      (bus.addr == `SCP_OFS_REVISION) ? REVISION_CODE :
      (bus.addr == `SCP_OFS_MAKER_LO) ? MAKER_CODE[7:0] :
      (bus.addr == `SCP_OFS_MAKER_HI) ? MAKER_CODE[15:8] :
      8'h00;

   assign bus.asc         = asc_reg;
   assign bus.four_wire   = four_wire_reg;
   assign bus.single_byte = single_reg;
   assign power_mode_field = pwr_act_reg;
endmodule

// *** scp_serial_port_properties.sv ***
// ------------------------------------------------------------
// port-level checks of the serial configuration port
// ------------------------------------------------------------
module scp_serial_port_properties (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              clk_en,
   input wire logic              port_select_n,
   input wire logic              serial_clk,
   input wire logic              sdio_in,
   input wire logic              sdio_out,
   input wire logic              sdio_oe,
   input wire logic              sdo_out,
   input wire logic              sdo_oe,
   input wire scp_pkg::scp_pwr_t power_mode_field
);
   timeunit 1ns;
   timeprecision 1ps;
   import scp_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // serial edges as the core sees them, one sample late
   sequence s_fall_seen;
      !$past(serial_clk) && $past(serial_clk, 2);
   endsequence
   sequence s_rise_seen;
      $past(serial_clk) && !$past(serial_clk, 2);
   endsequence
   sequence s_rise_load;
      $past(serial_clk, 2) && !$past(serial_clk, 3);
   endsequence

   // read bits move only after a fall, or a byte load after a rise
   property p_bit_step;
      $changed(sdo_out) |-> s_fall_seen or s_rise_load;
   endproperty

   a_oe_exclusive: assert property (!(sdio_oe && sdo_oe))
      else $error("both read data outputs enabled");
   a_out_twin: assert property (sdio_out == sdo_out)
      else $error("shared and separate read bits differ");
   a_oe_select: assert property (port_select_n && $past(port_select_n)
      |-> !sdio_oe && !sdo_oe)
      else $error("read output enabled while deselected");
   a_oe_launch: assert property ($rose(sdio_oe || sdo_oe)
      |-> s_rise_seen)
      else $error("read output enabled off a serial rise");
   a_bit_step: assert property (p_bit_step)
      else $error("read bit moved off schedule");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sdio_oe
      && !sdo_oe && !sdo_out && power_mode_field == 2'h0)
      else $error("outputs not quiet after reset");
   a_power_commit: assert property ($changed(power_mode_field)
      |-> $past(!port_select_n, 2))
      else $error("power mode moved outside a frame");
   a_freeze_hold: assert property (!clk_en |=> $stable(power_mode_field)
      && $stable(sdo_out))
      else $error("state moved with clock enable low");
endmodule

bind scp_serial_port scp_serial_port_properties u_props (
   .core_clk         (core_clk),
   .rst              (rst),
   .clk_en           (clk_en),
   .port_select_n    (port_select_n),
   .serial_clk       (serial_clk),
   .sdio_in          (sdio_in),
   .sdio_out         (sdio_out),
   .sdio_oe          (sdio_oe),
   .sdo_out          (sdo_out),
   .sdo_oe           (sdo_oe),
   .power_mode_field (power_mode_field)
);

// *** scp_host_model.sv ***
// ------------------------------------------------------------
// serial host on the far side of the control port
// ------------------------------------------------------------
module scp_host_model (
   input  wire logic core_clk,
   output logic      port_select_n,
   output logic      serial_clk,
   output wire logic sdio_in,
   input  wire logic sdio_out,
   input  wire logic sdio_oe,
   input  wire logic sdo_out,
   input  wire logic sdo_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic h_oe;
   logic h_bit;
   logic tog;
   wire  sdo_line;

   initial begin
      port_select_n = 1'b1;
      serial_clk    = 1'b0;
      h_oe          = 1'b1;
      h_bit         = 1'b0;
      tog           = 1'b0;
   end

   // released lines wobble so a stale bit never looks valid
   always @(posedge core_clk) begin
      tog <= ~tog;
   end
   assign sdio_in  = sdio_oe ? sdio_out : (h_oe ? h_bit : tog);
   assign sdo_line = sdo_oe ? sdo_out : tog;

   // config A low nibble must echo the high nibble reversed
   function automatic logic [7:0] mirror(input logic [7:0] v);
      return {v[7:4], v[4], v[5], v[6], v[7]};
   endfunction

   // one select-low frame, msb first; host lets go from bit rel
   task automatic frame(input int nbits, input logic [47:0] sh,
                        input int rel, input logic fw,
                        output logic [31:0] q);
      q = '0;
      @(posedge core_clk);
      port_select_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(posedge core_clk);
         h_oe  <= (i < rel);
         h_bit <= sh[47-i];
         repeat (3) @(posedge core_clk);
         @(negedge core_clk);
         q = {q[30:0], fw ? sdo_line : sdio_in};
         @(posedge core_clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge core_clk);
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      port_select_n <= 1'b1;
      h_oe          <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

// *** testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import scp_pkg::*;
   // identity values are arbitrary
   localparam logic [7:0]  CAT = 8'h6b;
   localparam logic [7:0]  ILO = 8'h2e;
   localparam logic [7:0]  IHI = 8'h71;
   localparam logic [7:0]  REV = 8'h09;
   localparam logic [15:0] MKR = 16'h5c3a;
   localparam int          LIMIT = 40000;

   logic        core_clk;
   logic        rst;
   logic        clk_en;
   logic        fw;
   logic [31:0] q;
   wire         csn;
   wire         sclk;
   wire         sdi;
   wire         sdio_out;
   wire         sdio_oe;
   wire         sdo_out;
   wire         sdo_oe;
   scp_pwr_t    pmf;
   scp_addr_t   ra [11];
   scp_byte_t   re [11];
   int          miscompares = 0;
   int          n_checks = 0;
   int          cyc = 0;

   scp_serial_port #(.CATEGORY_CODE(CAT), .IDENT_LO_CODE(ILO),
      .IDENT_HI_CODE(IHI), .REVISION_CODE(REV), .MAKER_CODE(MKR)) u_dut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .port_select_n(csn), .serial_clk(sclk), .sdio_in(sdi),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .power_mode_field(pmf));
   scp_host_model u_host (
      .core_clk(core_clk), .port_select_n(csn), .serial_clk(sclk),
      .sdio_in(sdi), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // hang guard, generous against roughly 40 frames
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         miscompares++;
         test_done();
      end
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input scp_addr_t a, input scp_byte_t d);
      u_host.frame(24, {1'b0, a, d, 24'h000000}, 24, fw, q);
   endtask
   task automatic rd(input scp_addr_t a, input int n,
                     input logic [31:0] exp);
      logic [31:0] m;
      m = (n == 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
      u_host.frame(16 + 8 * n, {1'b1, a, 32'h0}, 16, fw, q);
      chk(q & m, exp);
   endtask
   task automatic test_end(input string s);
      $display("test %s done", s);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst    = 1'b1;
      clk_en = 1'b1;
      fw     = 1'b0;
      ra = '{15'h0, 15'h1, 15'h2, 15'h3, 15'h4, 15'h5, 15'h6, 15'h7,
             15'hc, 15'hd, 15'hf};
      re = '{8'h00, 8'h00, 8'h00, CAT, ILO, IHI, REV, 8'h00,
             MKR[7:0], MKR[15:8], 8'h00};
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // reset values and read-only codes over the shared line
      for (int i = 0; i < 11; i++) rd(ra[i], 1, {24'h0, re[i]});
      wr(15'h3, 8'hff);
      wr(15'h8, 8'h55);
      rd(15'h3, 1, {24'h0, CAT});
      rd(15'h8, 1, 32'h0);
      test_end("identity");
      // four-wire on through a mirrored write, read back, then the mirror guard drops a bad write
      wr(15'h0, u_host.mirror(8'h30));
      fw = 1'b1;
      rd(15'h0, 1, 32'h3c);
      wr(15'h0, 8'h20);
      rd(15'h0, 1, 32'h3c);
      test_end("mirror");
      // streaming up, then down
      rd(15'h4, 3, {8'h0, ILO, IHI, REV});
      wr(15'h0, u_host.mirror(8'h10));
      rd(15'hd, 2, {16'h0, MKR});
      wr(15'h0, u_host.mirror(8'h00));
      fw = 1'b0;
      rd(15'h0, 1, 32'h0);
      test_end("stream");
      // pending versus active power mode and commit
      wr(15'h2, 8'h03);
      chk({30'h0, pmf}, 32'h0);
      rd(15'h2, 1, 32'h0);
      wr(15'h1, 8'h20);
      rd(15'h2, 1, 32'h3);
      wr(15'hf, 8'h01);
      chk({30'h0, pmf}, 32'h3);
      rd(15'hf, 1, 32'h0);
      test_end("commit");
      // soft reset spares config A and B
      wr(15'h0, u_host.mirror(8'h30));
      fw = 1'b1;
      chk({30'h0, pmf}, 32'h3);
      wr(15'h0, u_host.mirror(8'hb0));
      chk({30'h0, pmf}, 32'h0);
      rd(15'h2, 1, 32'h0);
      rd(15'h1, 1, 32'h20);
      rd(15'h0, 1, 32'h3c);
      test_end("soft_reset");
      // a frozen pause must not disturb the port
      clk_en <= 1'b0;
      repeat (6) @(posedge core_clk);
      clk_en <= 1'b1;
      rd(15'h3, 1, {24'h0, CAT});
      // single-byte: second instruction inside one select
      wr(15'h1, 8'ha0);
      u_host.frame(48, {16'h0002, 8'h01, 16'h8002, 8'h00}, 40, fw, q);
      chk({24'h0, q[7:0]}, 32'h01);
      wr(15'h1, 8'h00);
      rd(15'h1, 1, 32'h0);
      test_end("single_byte");
      test_done();
   end
endmodule
